// ==== rtl/xbp_crossbar_top.sv ====
// crossbar pin assignment, port 0/1 pin logic and port 1 registers
`timescale 1ns/1ps
`include "xbp_defines.svh"
// What this block does
// - only peripherals whose enable bits are set get routed
// - no pin assignment until the global crossbar enable is set
// - first uart highest priority: transmit on P0.0, receive on P0.1
// - smbus next: data then clock on next free pins
// - second uart, then irq a, then irq b, each on next free pin
// - skipped pins are passed over, port 0 continues into port 1
// - memory interface on low ports skips P0.6 and P0.7 strobes
// - multiplexed memory mode also skips P0.5 latch strobe
// - port 1 pins in analog input mode are skipped
// - multiplexed low-port memory drives ports 2 and 3 only during off-chip access
// - output mode 1 is push-pull, 0 is open-drain
// - port 1 latch drives unclaimed pins; open-drain 1 floats, 0 pulls low
// - port 1 read returns pin level regardless of crossbar
// - input mode 0: analog, reads return 0, pull-up off
// - input mode 1: digital read, pull-up set by global disable bit
// - analog pins keep driver following latch and output mode
// - non-multiplexed low-port memory mode drives port 1 with address high byte during off-chip access
// - memory port select 0 places interface on low ports, 1 on high
// - multiplex select 0 means multiplexed, 1 means separate pins
module xbp_crossbar_top (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // special-register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // peripheral side
  input wire logic first_uart_transmit,
  output logic first_uart_receive,
  input wire logic smb_sda_drive_low,
  input wire logic smb_scl_drive_low,
  output logic smb_sda_in,
  output logic smb_scl_in,
  input wire logic second_uart_transmit,
  output logic second_uart_receive,
  output logic ext_irq_a_input,
  output logic ext_irq_b_input,
  // memory interface side
  input wire logic memif_offchip_busy,
  input wire logic [15:0] memif_addr,
  input wire logic [7:0] memif_wdata,
  input wire logic memif_data_drive,
  input wire logic memif_rd_n,
  input wire logic memif_wr_n,
  input wire logic memif_ale,
  output logic [7:0] memif_rdata,
  // port 0 and port 1 pins
  input wire logic [7:0] p0_pin_in,
  output logic [7:0] p0_pin_out,
  output logic [7:0] p0_pin_oe,
  output logic [7:0] p0_pullup_en,
  input wire logic [7:0] p1_pin_in,
  output logic [7:0] p1_pin_out,
  output logic [7:0] p1_pin_oe,
  output logic [7:0] p1_pullup_en,
  // port 2 and port 3 pins, memory interface only
  input wire logic [7:0] p3_pin_in,
  output logic [7:0] p2_pin_out,
  output logic [7:0] p2_pin_oe,
  output logic [7:0] p3_pin_out,
  output logic [7:0] p3_pin_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] p1_latch_r;
  logic [7:0] p1_inmode_r;
  logic [7:0] p0_latch_r;
  logic [7:0] p0_outmode_r;
  logic [7:0] p1_outmode_r;
  logic [7:0] xb_cfg_a_r;
  logic [7:0] xb_cfg_b_r;
  logic [7:0] xb_cfg_c_r;
  logic [7:0] memif_cfg_r;
  logic [7:0] sfr_rdata_nxt;

  // pin synchronisers
  logic [7:0] p0_meta_r;
  logic [7:0] p0_sync_r;
  logic [7:0] p1_meta_r;
  logic [7:0] p1_sync_r;
  logic [7:0] p3_meta_r;
  logic [7:0] p3_sync_r;

  // crossbar map
  logic [15:0] skip;
  logic [7:0] sig_en;
  xbp_pkg::xbp_owner_t pin_owner;
  logic [15:0] pin_used;
  xbp_pkg::xbp_place_t sig_pin;
  logic [7:0] sig_placed;

  // decoded modes
  logic xbar_en;
  logic weak_pud;
  logic memif_low;
  logic memif_mux;
  logic low_skip;
  logic [15:0] all_sync;
  logic [15:0] all_latch;
  logic [15:0] all_mode;
  logic [15:0] xb_out;
  logic [15:0] all_out;
  logic [15:0] all_oe;

  // drive enable of a pin given its level and push-pull mode
  function automatic logic pin_oe(input logic val, input logic push_pull);
    pin_oe = push_pull | ~val;
  endfunction : pin_oe

  // level seen by a peripheral input routed to a pin; idle high when unplaced
  function automatic logic route_in(input logic placed, input logic [3:0] idx,
                                    input logic [15:0] lvl);
    route_in = placed ? lvl[idx] : 1'b1;
  endfunction : route_in

  ////////////////////////////////////////////////////////////////////////////
  // register writes
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      p1_latch_r <= `XBP_RST_P1_LATCH;
      p1_inmode_r <= `XBP_RST_P1_INMODE;
      p0_latch_r <= `XBP_RST_P0_LATCH;
      p0_outmode_r <= `XBP_RST_OUTMODE;
      p1_outmode_r <= `XBP_RST_OUTMODE;
      xb_cfg_a_r <= `XBP_RST_XB_CFG;
      xb_cfg_b_r <= `XBP_RST_XB_CFG;
      xb_cfg_c_r <= `XBP_RST_XB_CFG;
      memif_cfg_r <= `XBP_RST_MEMIF_CFG;
    end else if (sfr_wr) begin
      if (sfr_addr == `XBP_ADDR_P1_LATCH) begin
        p1_latch_r <= sfr_wdata;
      end else if (sfr_addr == `XBP_ADDR_P1_INMODE) begin
        p1_inmode_r <= sfr_wdata;
      end else if (sfr_addr == `XBP_ADDR_P0_LATCH) begin
        p0_latch_r <= sfr_wdata;
      end else if (sfr_addr == `XBP_ADDR_P0_OUTMODE) begin
        p0_outmode_r <= sfr_wdata;
      end else if (sfr_addr == `XBP_ADDR_P1_OUTMODE) begin
        p1_outmode_r <= sfr_wdata;
      end else if (sfr_addr == `XBP_ADDR_XB_CFG_A) begin
        xb_cfg_a_r <= sfr_wdata;
      end else if (sfr_addr == `XBP_ADDR_XB_CFG_B) begin
        xb_cfg_b_r <= sfr_wdata;
      end else if (sfr_addr == `XBP_ADDR_XB_CFG_C) begin
        xb_cfg_c_r <= sfr_wdata;
      end else if (sfr_addr == `XBP_ADDR_MEMIF_CFG) begin
        memif_cfg_r <= sfr_wdata & `XBP_MEMIF_CFG_MASK;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register reads; port 1 data reads the pins, not the latch
  always_comb begin
    if (sfr_addr == `XBP_ADDR_P1_LATCH) begin
      sfr_rdata_nxt = p1_sync_r & p1_inmode_r;
    end else if (sfr_addr == `XBP_ADDR_P1_INMODE) begin
      sfr_rdata_nxt = p1_inmode_r;
    end else if (sfr_addr == `XBP_ADDR_P0_LATCH) begin
      sfr_rdata_nxt = p0_sync_r;
    end else if (sfr_addr == `XBP_ADDR_P0_OUTMODE) begin
      sfr_rdata_nxt = p0_outmode_r;
    end else if (sfr_addr == `XBP_ADDR_P1_OUTMODE) begin
      sfr_rdata_nxt = p1_outmode_r;
    end else if (sfr_addr == `XBP_ADDR_XB_CFG_A) begin
      sfr_rdata_nxt = xb_cfg_a_r;
    end else if (sfr_addr == `XBP_ADDR_XB_CFG_B) begin
      sfr_rdata_nxt = xb_cfg_b_r;
    end else if (sfr_addr == `XBP_ADDR_XB_CFG_C) begin
      sfr_rdata_nxt = xb_cfg_c_r;
    end else if (sfr_addr == `XBP_ADDR_MEMIF_CFG) begin
      sfr_rdata_nxt = memif_cfg_r;
    end else begin
      sfr_rdata_nxt = 8'h00; // unmapped reads as zero
    end
  end

  // read data registered one cycle after the strobe
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd) begin
      sfr_rdata <= sfr_rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // two-flop synchronisers on every pin input
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      p0_meta_r <= 8'hFF;
      p0_sync_r <= 8'hFF;
      p1_meta_r <= 8'hFF;
      p1_sync_r <= 8'hFF;
      p3_meta_r <= 8'h00;
      p3_sync_r <= 8'h00;
    end else begin
      p0_meta_r <= p0_pin_in;
      p0_sync_r <= p0_meta_r;
      p1_meta_r <= p1_pin_in;
      p1_sync_r <= p1_meta_r;
      p3_meta_r <= p3_pin_in;
      p3_sync_r <= p3_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode decode and skip mask
  assign xbar_en = xb_cfg_c_r[`XBP_BIT_XBAR_EN];
  assign weak_pud = xb_cfg_c_r[`XBP_BIT_WEAK_PUD];
  assign low_skip = xb_cfg_c_r[`XBP_BIT_MEMIF_LOW_SKIP];
  assign memif_low = ~memif_cfg_r[`XBP_BIT_MEMIF_PORT_SEL];
  assign memif_mux = ~memif_cfg_r[`XBP_BIT_MEMIF_MUX_SEL];

  // enables in priority order; transmit/receive pairs share one bit
  assign sig_en = {xb_cfg_b_r[`XBP_BIT_IRQ_B_EN], xb_cfg_b_r[`XBP_BIT_IRQ_A_EN],
                   {2{xb_cfg_c_r[`XBP_BIT_UART1_EN]}}, {2{xb_cfg_a_r[`XBP_BIT_SMBUS_EN]}},
                   {2{xb_cfg_a_r[`XBP_BIT_UART0_EN]}}};

  // strobe pins and analog port 1 pins are passed over
  always_comb begin
    skip = '0;
    skip[`XBP_PIN_RD] = low_skip;
    skip[`XBP_PIN_WR] = low_skip;
    skip[`XBP_PIN_ALE] = low_skip & memif_mux;
    skip[15:8] = ~p1_inmode_r;
  end

  xbp_pin_alloc u_alloc (
    .clock(clock),
    .sys_rst(sys_rst),
    .xbar_en(xbar_en),
    .sig_en(sig_en),
    .skip(skip),
    .pin_owner(pin_owner),
    .pin_used(pin_used),
    .sig_pin(sig_pin),
    .sig_placed(sig_placed)
  );

  ////////////////////////////////////////////////////////////////////////////
  // peripheral inputs come from the synchronised pin levels
  assign all_sync = {p1_sync_r, p0_sync_r};
  assign all_latch = {p1_latch_r, p0_latch_r};
  assign all_mode = {p1_outmode_r, p0_outmode_r};

  always_comb begin
    first_uart_receive = route_in(sig_placed[xbp_pkg::SIG_U0_RX],
                                  sig_pin[xbp_pkg::SIG_U0_RX], all_sync);
    smb_sda_in = route_in(sig_placed[xbp_pkg::SIG_SMB_SDA],
                          sig_pin[xbp_pkg::SIG_SMB_SDA], all_sync);
    smb_scl_in = route_in(sig_placed[xbp_pkg::SIG_SMB_SCL],
                          sig_pin[xbp_pkg::SIG_SMB_SCL], all_sync);
    second_uart_receive = route_in(sig_placed[xbp_pkg::SIG_U1_RX],
                                   sig_pin[xbp_pkg::SIG_U1_RX], all_sync);
    ext_irq_a_input = route_in(sig_placed[xbp_pkg::SIG_IRQ_A],
                               sig_pin[xbp_pkg::SIG_IRQ_A], all_sync);
    ext_irq_b_input = route_in(sig_placed[xbp_pkg::SIG_IRQ_B],
                               sig_pin[xbp_pkg::SIG_IRQ_B], all_sync);
  end

  ////////////////////////////////////////////////////////////////////////////
  // port 0 and port 1 drivers
  always_comb begin
    for (int p = 0; p < 16; p++) begin
      // peripheral value of the pin's owner; inputs release the pin high
      case (pin_owner[p])
        xbp_pkg::SIG_U0_TX: xb_out[p] = first_uart_transmit;
        xbp_pkg::SIG_SMB_SDA: xb_out[p] = ~smb_sda_drive_low;
        xbp_pkg::SIG_SMB_SCL: xb_out[p] = ~smb_scl_drive_low;
        xbp_pkg::SIG_U1_TX: xb_out[p] = second_uart_transmit;
        default: xb_out[p] = 1'b1;
      endcase
      if (pin_used[p]) begin
        all_out[p] = xb_out[p];
        // smbus lines stay open-drain whatever the mode bit says
        if (pin_owner[p] == xbp_pkg::SIG_SMB_SDA || pin_owner[p] == xbp_pkg::SIG_SMB_SCL) begin
          all_oe[p] = ~xb_out[p];
        end else begin
          all_oe[p] = pin_oe(xb_out[p], all_mode[p]);
        end
      end else begin
        all_out[p] = all_latch[p];
        all_oe[p] = pin_oe(all_latch[p], all_mode[p]);
      end
    end
    // memory strobes own their pins on the low ports
    if (memif_low && low_skip) begin
      all_out[`XBP_PIN_RD] = memif_rd_n;
      all_oe[`XBP_PIN_RD] = pin_oe(memif_rd_n, all_mode[`XBP_PIN_RD]);
      all_out[`XBP_PIN_WR] = memif_wr_n;
      all_oe[`XBP_PIN_WR] = pin_oe(memif_wr_n, all_mode[`XBP_PIN_WR]);
      if (memif_mux) begin
        all_out[`XBP_PIN_ALE] = memif_ale;
        all_oe[`XBP_PIN_ALE] = pin_oe(memif_ale, all_mode[`XBP_PIN_ALE]);
      end
    end
    // separate-pin mode: port 1 carries the high address byte during access
    if (memif_low && !memif_mux && memif_offchip_busy) begin
      all_out[15:8] = memif_addr[15:8];
      all_oe[15:8] = 8'hFF;
    end
  end

  assign p0_pin_out = all_out[7:0];
  assign p0_pin_oe = all_oe[7:0];
  assign p1_pin_out = all_out[15:8];
  assign p1_pin_oe = all_oe[15:8];

  // weak pull-ups: global disable, and never on an analog port 1 pin
  assign p0_pullup_en = {8{~weak_pud}};
  assign p1_pullup_en = p1_inmode_r & {8{~weak_pud}};

  ////////////////////////////////////////////////////////////////////////////
  // ports 2 and 3: driven only while an off-chip access runs, else floated
  always_comb begin
    p2_pin_out = 8'h00;
    p2_pin_oe = 8'h00;
    p3_pin_out = 8'h00;
    p3_pin_oe = 8'h00;
    if (memif_low && memif_offchip_busy) begin
      if (memif_mux) begin
        p2_pin_out = memif_addr[15:8];
        p2_pin_oe = 8'hFF;
        p3_pin_out = memif_ale ? memif_addr[7:0] : memif_wdata;
        p3_pin_oe = {8{memif_ale | memif_data_drive}};
      end else begin
        p2_pin_out = memif_addr[7:0];
        p2_pin_oe = 8'hFF;
        p3_pin_out = memif_wdata;
        p3_pin_oe = {8{memif_data_drive}};
      end
    end
  end

  // read data from the data pins, synchronised
  assign memif_rdata = p3_sync_r;

endmodule : xbp_crossbar_top

// ==== rtl/xbp_defines.svh ====
// register offsets, field positions, reset values for the crossbar and port 1 block
`ifndef XBP_DEFINES_SVH
`define XBP_DEFINES_SVH

// register addresses on the special-register port
`define XBP_ADDR_P1_LATCH 8'h90
`define XBP_ADDR_P1_INMODE 8'hAD
`define XBP_ADDR_MEMIF_CFG 8'hA3
`define XBP_ADDR_P0_LATCH 8'h80
`define XBP_ADDR_P0_OUTMODE 8'hA4
`define XBP_ADDR_P1_OUTMODE 8'hA5
`define XBP_ADDR_XB_CFG_A 8'hE1
`define XBP_ADDR_XB_CFG_B 8'hE2
`define XBP_ADDR_XB_CFG_C 8'hE3

// reset values
`define XBP_RST_P1_LATCH 8'hFF
`define XBP_RST_P1_INMODE 8'hFF
`define XBP_RST_P0_LATCH 8'hFF
`define XBP_RST_OUTMODE 8'h00
`define XBP_RST_XB_CFG 8'h00
`define XBP_RST_MEMIF_CFG 8'h03

// crossbar_config_a fields
`define XBP_BIT_SMBUS_EN 0
`define XBP_BIT_UART0_EN 2
// crossbar_config_b fields
`define XBP_BIT_IRQ_A_EN 2
`define XBP_BIT_IRQ_B_EN 4
// crossbar_config_c fields
`define XBP_BIT_MEMIF_LOW_SKIP 1
`define XBP_BIT_UART1_EN 2
`define XBP_BIT_XBAR_EN 6
`define XBP_BIT_WEAK_PUD 7
// memory interface configuration fields
`define XBP_BIT_MEMIF_MUX_SEL 4
`define XBP_BIT_MEMIF_PORT_SEL 5
`define XBP_MEMIF_CFG_MASK 8'h3F

// pin indices of the memory strobes on port 0
`define XBP_PIN_ALE 5
`define XBP_PIN_RD 6
`define XBP_PIN_WR 7

`endif

// ==== rtl/xbp_pkg.sv ====
// types shared by the crossbar and port 1 block
package xbp_pkg;

  // crossbar signals in priority order
  typedef enum logic [2:0] {
    SIG_U0_TX = 3'h0,
    SIG_U0_RX = 3'h1,
    SIG_SMB_SDA = 3'h2,
    SIG_SMB_SCL = 3'h3,
    SIG_U1_TX = 3'h4,
    SIG_U1_RX = 3'h5,
    SIG_IRQ_A = 3'h6,
    SIG_IRQ_B = 3'h7
  } xbp_sig_t;

  typedef logic [15:0][2:0] xbp_owner_t;
  typedef logic [7:0][3:0] xbp_place_t;

endpackage : xbp_pkg

// ==== rtl/xbp_pin_alloc.sv ====
// priority pin allocator: walks enabled signals over non-skipped pins
`timescale 1ns/1ps
module xbp_pin_alloc (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // configuration
  input wire logic xbar_en,
  input wire logic [7:0] sig_en,
  input wire logic [15:0] skip,
  // registered assignment
  output xbp_pkg::xbp_owner_t pin_owner,
  output logic [15:0] pin_used,
  output xbp_pkg::xbp_place_t sig_pin,
  output logic [7:0] sig_placed
);

  xbp_pkg::xbp_owner_t owner_nxt;
  logic [15:0] used_nxt;
  xbp_pkg::xbp_place_t spin_nxt;
  logic [7:0] placed_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // each enabled signal takes the lowest free pin above the previous one
  always_comb begin
    int ptr;
    logic found;
    ptr = 0;
    found = 1'b0;
    owner_nxt = '0;
    used_nxt = '0;
    spin_nxt = '0;
    placed_nxt = '0;
    for (int s = 0; s < 8; s++) begin
      found = 1'b0;
      if (xbar_en && sig_en[s]) begin
        for (int p = 0; p < 16; p++) begin
          if (!found && p >= ptr && !skip[p]) begin
            found = 1'b1;
            used_nxt[p] = 1'b1;
            owner_nxt[p] = 3'(s);
            spin_nxt[s] = 4'(p);
            placed_nxt[s] = 1'b1;
            ptr = p + 1;
          end
        end
      end
    end
  end

  // registered so pin muxes see a stable map; one cycle lag after a write
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pin_owner <= '0;
      pin_used <= '0;
      sig_pin <= '0;
      sig_placed <= '0;
    end else begin
      pin_owner <= owner_nxt;
      pin_used <= used_nxt;
      sig_pin <= spin_nxt;
      sig_placed <= placed_nxt;
    end
  end

endmodule : xbp_pin_alloc

// ==== sim/xbp_crossbar_assertions.sv ====
// checker for the crossbar and port 1 block, bound to its top module
`timescale 1ns/1ps
module xbp_crossbar_checker (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  // peripheral and memory side
  input wire logic first_uart_receive,
  input wire logic ext_irq_b_input,
  input wire logic memif_offchip_busy,
  input wire logic [15:0] memif_addr,
  // pins
  input wire logic [7:0] p1_pin_in,
  input wire logic [7:0] p1_pin_out,
  input wire logic [7:0] p1_pin_oe,
  input wire logic [7:0] p1_pullup_en,
  input wire logic [7:0] p2_pin_oe,
  input wire logic [7:0] p3_pin_oe
);
  logic [7:0] lat_r, inm_r, om_r, cfgc_r, mcfg_r;
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
////////////////////////////////////////
  // register shadows, so pin relations need no view inside the design
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      lat_r <= 8'hFF;
      inm_r <= 8'hFF;
      om_r <= 8'h00;
      cfgc_r <= 8'h00;
      mcfg_r <= 8'h03;
    end else if (sfr_wr) begin
      case (sfr_addr)
        8'h90: lat_r <= sfr_wdata;
        8'hAD: inm_r <= sfr_wdata;
        8'hA5: om_r <= sfr_wdata;
        8'hE3: cfgc_r <= sfr_wdata;
        8'hA3: mcfg_r <= sfr_wdata & 8'h3F;
        default: ;
      endcase
    end
  end
////////////////////////////////////////
  // two quiet cycles cover the synchroniser depth, so a read right after a write is not checked
  a_p1_read_level: assert property ((!sys_rst && !sfr_wr && $stable(p1_pin_in))[*2] ##0
      (sfr_rd && sfr_addr == 8'h90) |=> sfr_rdata == ($past(p1_pin_in) & $past(inm_r)))
    else $error("port 1 read wrong");
  a_inmode_readback: assert property (sfr_rd && sfr_addr == 8'hAD |=>
      sfr_rdata == $past(inm_r)) else $error("input mode readback wrong");
  a_memif_cfg_read: assert property (sfr_rd && sfr_addr == 8'hA3 |=>
      sfr_rdata == $past(mcfg_r)) else $error("memory config readback wrong");
  a_pullup_follow: assert property (p1_pullup_en == (inm_r & ~{8{cfgc_r[7]}}))
    else $error("pull-up enable wrong");
  // map lags the enable by one edge, hence the past term
  a_gpio_oe_mode: assert property (!cfgc_r[6] && !$past(cfgc_r[6]) && !memif_offchip_busy
      |-> p1_pin_oe == (om_r | ~lat_r)) else $error("port 1 drive enable wrong");
  a_gpio_level: assert property (!cfgc_r[6] && !$past(cfgc_r[6]) && !memif_offchip_busy
      |-> (p1_pin_out & p1_pin_oe) == (lat_r & p1_pin_oe)) else $error("port 1 level wrong");
  a_xbar_gated: assert property (!cfgc_r[6] && !$past(cfgc_r[6])
      |-> first_uart_receive && ext_irq_b_input) else $error("routed while disabled");
  a_ports_idle: assert property (!memif_offchip_busy |-> p2_pin_oe == 8'h00
      && p3_pin_oe == 8'h00) else $error("ports 2 and 3 driven while idle");
  a_addr_high: assert property (memif_offchip_busy && mcfg_r[5:4] == 2'h1
      |-> p1_pin_oe == 8'hFF && p1_pin_out == memif_addr[15:8]) else $error("address byte");
  c_p1_read: cover property (sfr_rd && sfr_addr == 8'h90);
  c_addr_drive: cover property (memif_offchip_busy && mcfg_r[4]);
  c_irq_routed: cover property (!ext_irq_b_input);
endmodule : xbp_crossbar_checker

bind xbp_crossbar_top xbp_crossbar_checker i_xbp_crossbar_checker (.*);

// ==== sim/xbp_pin_env.sv ====
// far-side pin model: external drivers, pull-ups and floating lines
`timescale 1ns/1ps
module xbp_pin_env (
  // clock
  input wire logic clock,
  // device drivers
  input wire logic [7:0] p0_pin_out,
  input wire logic [7:0] p0_pin_oe,
  input wire logic [7:0] p0_pullup_en,
  input wire logic [7:0] p1_pin_out,
  input wire logic [7:0] p1_pin_oe,
  input wire logic [7:0] p1_pullup_en,
  input wire logic [7:0] p3_pin_out,
  input wire logic [7:0] p3_pin_oe,
  // outside drive, port 0 in the low byte
  input wire logic [15:0] ext_en,
  input wire logic [15:0] ext_val,
  // resolved pin levels
  output logic [7:0] p0_pin_in,
  output logic [7:0] p1_pin_in,
  output logic [7:0] p3_pin_in
);
  logic [15:0] float_r = 16'h5A5A;
  logic [15:0] oe, lvl;
////////////////////////////////////////
  // a released line without pull-up toggles, so no settled value fakes a match
  always @(posedge clock) begin
    float_r <= ~float_r;
  end
  // device driver wins, then outside drive, then pull-up or floating
  assign oe = {p1_pin_oe, p0_pin_oe};
  assign lvl = (oe & {p1_pin_out, p0_pin_out}) | (~oe & ext_en & ext_val)
      | (~oe & ~ext_en & ({p1_pullup_en, p0_pullup_en} | float_r));
  assign {p1_pin_in, p0_pin_in} = lvl;
  assign p3_pin_in = (p3_pin_oe & p3_pin_out) | (~p3_pin_oe & float_r[7:0]);
endmodule : xbp_pin_env

// ==== sim/tb_xbp_crossbar_top.sv ====
// testbench for the crossbar and port 1 block
`timescale 1ns/1ps
module tb_xbp_crossbar_top;
  typedef struct packed {
    logic [7:0] a, b, c, m, inm;
    logic [4:0] rx0, scl, tx1, rx1, ia, ib;
  } xbp_row_t;
  logic clock, sys_rst, sfr_wr, sfr_rd, memif_offchip_busy, memif_data_drive;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, memif_wdata, memif_rdata;
  logic first_uart_transmit, first_uart_receive, smb_sda_drive_low, smb_scl_drive_low;
  logic smb_sda_in, smb_scl_in, second_uart_transmit, second_uart_receive;
  logic ext_irq_a_input, ext_irq_b_input, memif_rd_n, memif_wr_n, memif_ale;
  logic [15:0] memif_addr, ext_en, ext_val, lvl, msk;
  logic [7:0] p0_pin_in, p0_pin_out, p0_pin_oe, p0_pullup_en, p1_pin_in, p1_pin_out;
  logic [7:0] p1_pin_oe, p1_pullup_en, p3_pin_in, p2_pin_out, p2_pin_oe, p3_pin_out, p3_pin_oe;
  logic [4:0] e, got;
  logic [4:0] pins [5];
  int bad_count = 0;
  int checks = 0;
  int cyc = 0;
  // config a, b, c, memory cfg, input mode; pins of rx0, scl, tx1, rx1, irq a, irq b (10 = none)
  xbp_row_t rows [7] = '{
    '{8'h05, 8'h14, 8'h46, 8'h00, 8'hE3, 5'h01, 5'h03, 5'h04, 5'h08, 5'h09, 5'h0D},
    '{8'h05, 8'h14, 8'h42, 8'h00, 8'hE3, 5'h01, 5'h03, 5'h10, 5'h10, 5'h04, 5'h08},
    '{8'h05, 8'h14, 8'h04, 8'h00, 8'hFF, 5'h10, 5'h10, 5'h10, 5'h10, 5'h10, 5'h10},
    '{8'h05, 8'h14, 8'h46, 8'h10, 8'hFF, 5'h01, 5'h03, 5'h04, 5'h05, 5'h08, 5'h09},
    '{8'h00, 8'h14, 8'h40, 8'h00, 8'hFE, 5'h10, 5'h10, 5'h10, 5'h10, 5'h00, 5'h01},
    '{8'h01, 8'h04, 8'h40, 8'h00, 8'h00, 5'h10, 5'h01, 5'h10, 5'h10, 5'h02, 5'h10},
    '{8'h05, 8'h14, 8'h46, 8'h00, 8'h00, 5'h01, 5'h03, 5'h04, 5'h10, 5'h10, 5'h10}};

  xbp_crossbar_top i_xbp_crossbar_top (.*);
  xbp_pin_env i_xbp_pin_env (.*);
  assign lvl = {p1_pin_in, p0_pin_in};
////////////////////////////////////////
  // clock, and a hang guard far above the few hundred cycles needed
  initial begin
    clock = 1'h0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 8000) begin
      bad_count++;
      wrap_up();
    end
  end
////////////////////////////////////////
  task automatic chk(input logic [15:0] got_v, input logic [15:0] exp_v);
    checks++;
    if (got_v !== exp_v) begin
      bad_count++;
      $display("Error %0t: got %h expected %h", $time, got_v, exp_v);
    end
  endtask : chk
  // one-cycle strobes, always separated by an idle cycle
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(negedge clock);
    sfr_addr = ad;
    sfr_wdata = d;
    sfr_wr = 1'h1;
    @(negedge clock);
    sfr_wr = 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] ad, input logic [7:0] x);
    @(negedge clock);
    sfr_addr = ad;
    sfr_rd = 1'h1;
    @(negedge clock);
    sfr_rd = 1'h0;
    chk({8'h00, sfr_rdata}, {8'h00, x});
  endtask : rd
  task automatic wrap_up;
    if (bad_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up
////////////////////////////////////////
  initial begin
    {sys_rst, sfr_wr, sfr_rd, memif_offchip_busy, memif_data_drive, memif_ale} = 6'h20;
    {first_uart_transmit, second_uart_transmit, memif_rd_n, memif_wr_n} = 4'hF;
    {smb_sda_drive_low, smb_scl_drive_low} = 2'h0;
    {sfr_addr, sfr_wdata, memif_wdata, memif_addr} = 40'h0;
    {ext_en, ext_val} = 32'hFFFF_FFFF;
    repeat (8) @(negedge clock);
    sys_rst = 1'h0;
    // each row: program the map, pull one pin low at a time, then drive the outputs
    foreach (rows[r]) begin
      wr(8'hE3, 8'h00);
      wr(8'hE1, rows[r].a);
      wr(8'hE2, rows[r].b);
      wr(8'hA3, rows[r].m);
      wr(8'hAD, rows[r].inm);
      wr(8'hE3, rows[r].c);
      pins = '{rows[r].rx0, rows[r].scl, rows[r].rx1, rows[r].ia, rows[r].ib};
      for (int s = 0; s < 5; s++) begin
        ext_val = 16'hFFFF;
        if (pins[s] != 5'h10) ext_val[pins[s][3:0]] = 1'h0;
        for (int t = 0; t < 5; t++) e[4 - t] = !(pins[t] == pins[s] && pins[s] != 5'h10);
        repeat (4) @(negedge clock);
        got = {first_uart_receive, smb_scl_in, second_uart_receive, ext_irq_a_input,
            ext_irq_b_input};
        chk({11'h0, got}, {11'h0, e});
      end
      // data line sits one pin below the clock line
      if (rows[r].scl != 5'h10) begin
        ext_val = 16'hFFFF;
        ext_val[rows[r].scl[3:0] - 4'h1] = 1'h0;
        repeat (4) @(negedge clock);
        chk({14'h0, smb_sda_in, smb_scl_in}, 16'h0001);
      end
      ext_en = 16'h0000;
      msk = 16'h0000;
      if (rows[r].rx0 != 5'h10) msk[rows[r].rx0[3:0] - 4'h1] = 1'h1;
      if (rows[r].scl != 5'h10) msk[rows[r].scl[3:0] -: 2] = 2'h3;
      if (rows[r].tx1 != 5'h10) msk[rows[r].tx1[3:0]] = 1'h1;
      {first_uart_transmit, second_uart_transmit, smb_sda_drive_low, smb_scl_drive_low} = 4'h3;
      repeat (2) @(negedge clock);
      chk(lvl & msk, 16'h0000);
      {first_uart_transmit, second_uart_transmit, smb_sda_drive_low, smb_scl_drive_low} = 4'hC;
      repeat (2) @(negedge clock);
      chk(lvl & msk, msk);
      ext_en = 16'hFFFF;
    end
    // second reset in mid-run, then reset values, readback and an unmapped place
    ext_val = 16'hFFFF;
    sys_rst = 1'h1;
    repeat (8) @(negedge clock);
    sys_rst = 1'h0;
    rd(8'h90, 8'hFF);
    rd(8'hAD, 8'hFF);
    rd(8'hA3, 8'h03);
    wr(8'h00, 8'h5A);
    rd(8'h00, 8'h00);
    chk({p1_pullup_en, p1_pin_oe}, 16'hFF00);
    // analog pins read 0 and lose the pull-up; global disable drops the rest
    ext_val = 16'hA5FF;
    wr(8'hAD, 8'h0F);
    rd(8'h90, 8'h05);
    chk({p0_pullup_en, p1_pullup_en}, 16'hFF0F);
    wr(8'hE3, 8'h80);
    chk({p0_pullup_en, p1_pullup_en}, 16'h0000);
    wr(8'hA3, 8'hFF);
    rd(8'hA3, 8'h3F);
    // crossbar off: port 1 is plain port logic, analog pins included
    ext_en = 16'h0000;
    wr(8'hA5, 8'h0F);
    wr(8'h90, 8'h3C);
    chk({p1_pin_oe, p1_pin_out & p1_pin_oe}, 16'hCF0C);
    wr(8'hA5, 8'h00);
    wr(8'h90, 8'hFF);
    chk({8'h00, p1_pin_oe}, 16'h0000);
    // port 0 push-pull on two pins, open-drain elsewhere
    wr(8'hA4, 8'h11);
    wr(8'h80, 8'h0F);
    chk({p0_pin_oe, p0_pin_out & p0_pin_oe}, 16'hF101);
    // memory interface takes ports 2 and 3, and port 1 in separate-pin mode, only while busy and on the low ports
    memif_addr = 16'hA55A;
    memif_wdata = 8'h3C;
    memif_data_drive = 1'h1;
    wr(8'hA3, 8'h10);
    memif_offchip_busy = 1'h1;
    @(negedge clock);
    chk({p1_pin_oe, p1_pin_out}, 16'hFFA5);
    repeat (2) @(negedge clock);
    chk({p3_pin_out, memif_rdata}, 16'h3C3C);
    memif_offchip_busy = 1'h0;
    @(negedge clock);
    chk({p2_pin_oe, p3_pin_oe}, 16'h0000);
    wr(8'hA3, 8'h00);
    memif_offchip_busy = 1'h1;
    @(negedge clock);
    chk({p2_pin_oe, p2_pin_out}, 16'hFFA5);
    wr(8'hA3, 8'h20);
    chk({p2_pin_oe, p3_pin_oe}, 16'h0000);
    memif_offchip_busy = 1'h0;
    wrap_up();
  end
endmodule : tb_xbp_crossbar_top
